// *** hdl/flow_computer_modbus_map.sv ***
// Host-visible register map of the flow computer with composition timeouts
// Notes on behaviour
// - Read-only virtual stream blocks, 42 registers each
// - Base volume, mass, energy totals wrap at limit
// - Premium volume total wraps at same limit
// - Premium mass and energy totals wrap too
// - Shared composition block at 818 feeds calculation
// - Shared block serves all streams one to eight
// - Read/write 16-bit timeout counter at 862
// - Counter above configured timeout raises alarm
// - Alarm substitutes keypad values in calculations
// - Block write clears its own timeout counter
// - Date word: day high, weekday low
// - Year word: year high, month low
// - Per-stream composition blocks, 54 registers from 870
// - Per-stream ranges each carry own timeout counter
`timescale 1ns/1ns
`default_nettype none
`include "flow_register_map.svh"

module flow_computer_modbus_map (
    input wire logic clk,
    input wire logic rst_n,
    input wire flow_computer_pkg::mb_req_s mb_req,
    output logic [15:0] mb_rdata,
    output logic mb_ack,
    output logic mb_err,
    input wire flow_computer_pkg::meas_upd_s meas_upd,
    input wire logic timeout_tick,
    input wire logic [15:0] update_timeout,
    input wire flow_computer_pkg::calc_req_s calc_req,
    output logic [31:0] calc_value,
    output logic calc_valid,
    output logic calc_substituted,
    output logic [8:0] timeout_alarm,
    output logic [79:0] clock_words
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    flow_computer_pkg::state_s st; // Registered state
    flow_computer_pkg::state_s next_st; // Next state

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // True for the float slots of a virtual stream that hold totals
    function automatic logic is_total(input int slot);
        logic hit;
        hit = (slot == int'(`MAP_TOT_VOL)) || (slot == int'(`MAP_TOT_MASS)) ||
              (slot == int'(`MAP_TOT_ENERGY));
        hit = hit || (slot == int'(`MAP_TOT_PVOL));
        hit = hit || (slot == int'(`MAP_TOT_PMASS)) ||
              (slot == int'(`MAP_TOT_PENERGY));
        return hit;
    endfunction

    // Range check on a date/time word before it is accepted
    function automatic logic dt_ok(input int w, input logic [15:0] d);
        logic [7:0] lo;
        logic [7:0] hi;
        logic ok;
        lo = d[`MAP_DT_LO_POS +: 8];
        hi = d[`MAP_DT_HI_POS +: 8];
        ok = 1'b0;
        unique case (w)
            0, 1: ok = (lo <= `MAP_SEC_MAX);
            2: ok = (lo <= `MAP_HOUR_MAX);
            3: ok = (hi >= 8'h01) && (hi <= `MAP_DAY_MAX) &&
                    (lo >= 8'h01) && (lo <= `MAP_WDAY_MAX);
            4: ok = (hi <= `MAP_YEAR_MAX) &&
                    (lo >= 8'h01) && (lo <= `MAP_MONTH_MAX);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------

    // Measurement updates, counters, host access and calculation lookups
    always_comb begin
        int a;
        int off;
        int s;
        int fi;
        int slot;
        logic [31:0] v;
        logic [31:0] stored;
        logic sub;
        logic [`MAP_CNT_COUNT-1:0] clr;
        a = int'(mb_req.addr);
        off = 0;
        s = 0;
        fi = 0;
        slot = 0;
        v = 32'h0000_0000;
        stored = 32'h0000_0000;
        sub = 1'b0;
        clr = '0;
        next_st = st;
        next_st.ack = 1'b0;
        next_st.err = 1'b0;
        next_st.cvalid = 1'b0;

        // Timeout counters count ticks and stop at the top value
        if (timeout_tick) begin
            for (int i = 0; i < int'(`MAP_CNT_COUNT); i++) begin
                if (st.cnt[i] != `MAP_CNT_MAX) begin
                    next_st.cnt[i] = st.cnt[i] + 16'h0001;
                end
            end
        end

        // Measurement engine loads one float; positive totals at or past the limit wrap to zero
        if (meas_upd.we && (int'(meas_upd.index) < int'(`MAP_RO_WORDS) / 2)) begin
            fi = int'(meas_upd.index);
            v = meas_upd.value;
            if (fi < int'(`MAP_VS_COUNT) * int'(`MAP_VS_FLOATS)) begin
                // Positive floats order like unsigned integers
                slot = fi % int'(`MAP_VS_FLOATS);
                if (is_total(slot) && !v[31] && (v >= `MAP_ROLLOVER)) begin
                    v = 32'h0000_0000;
                end
            end
            next_st.ro[2 * fi] = v[31:16];
            next_st.ro[2 * fi + 1] = v[15:0];
        end

        // Host access: one answer per request, next cycle
        if (mb_req.rd || mb_req.wr) begin
            next_st.ack = 1'b1;
            if (mb_req.rd) begin
                next_st.rdata = 16'h0000;
            end
            if ((a >= int'(`MAP_VS_BASE)) &&
                (a < int'(`MAP_VS_BASE) + int'(`MAP_RO_WORDS))) begin
                // Virtual streams and flow rates: read only
                off = a - int'(`MAP_VS_BASE);
                if (mb_req.rd) begin
                    next_st.rdata = st.ro[off];
                end else begin
                    next_st.err = 1'b1;
                end
            end else if ((a >= int'(`MAP_SH_BASE)) &&
                         (a < int'(`MAP_SH_BASE) + int'(`MAP_SH_WORDS))) begin
                // Shared composition block
                off = a - int'(`MAP_SH_BASE);
                if (mb_req.rd) begin
                    next_st.rdata = st.sh[off];
                end else begin
                    next_st.sh[off] = mb_req.wdata;
                    clr[0] = 1'b1;
                end
            end else if (a == int'(`MAP_TO_ADDR)) begin
                // Shared block timeout counter, directly writable
                if (mb_req.rd) begin
                    next_st.rdata = st.cnt[0];
                end else begin
                    next_st.cnt[0] = mb_req.wdata;
                end
            end else if ((a >= int'(`MAP_DT_BASE)) &&
                         (a < int'(`MAP_DT_BASE) + int'(`MAP_DT_WORDS))) begin
                // Date/time words; out-of-range fields are refused
                off = a - int'(`MAP_DT_BASE);
                if (mb_req.rd) begin
                    next_st.rdata = st.dt[off];
                end else if (dt_ok(off, mb_req.wdata)) begin
                    next_st.dt[off] = mb_req.wdata;
                end else begin
                    next_st.err = 1'b1;
                end
            end else if ((a >= int'(`MAP_PS_BASE)) &&
                         (a < int'(`MAP_PS_BASE) + int'(`MAP_PS_ALL))) begin
                // Per-stream composition blocks
                s = (a - int'(`MAP_PS_BASE)) / int'(`MAP_PS_WORDS);
                off = (a - int'(`MAP_PS_BASE)) % int'(`MAP_PS_WORDS);
                if (off < int'(`MAP_PS_TO_OFF)) begin
                    if (mb_req.rd) begin
                        next_st.rdata = st.ps[a - int'(`MAP_PS_BASE)];
                    end else begin
                        next_st.ps[a - int'(`MAP_PS_BASE)] = mb_req.wdata;
                        clr[s + 1] = 1'b1;
                    end
                end else if (off == int'(`MAP_PS_TO_OFF)) begin
                    // Each stream range has its own counter
                    if (mb_req.rd) begin
                        next_st.rdata = st.cnt[s + 1];
                    end else begin
                        next_st.cnt[s + 1] = mb_req.wdata;
                    end
                end
                // Last word of each stream range reads zero, writes are dropped
            end else begin
                // Unmapped address
                next_st.err = 1'b1;
            end
        end

        // A block update wins over a tick in the same cycle
        for (int i = 0; i < int'(`MAP_CNT_COUNT); i++) begin
            if (clr[i]) begin
                next_st.cnt[i] = `MAP_WORD_RESET;
            end
        end

        // Alarm follows the counter against the configured timeout
        for (int i = 0; i < int'(`MAP_CNT_COUNT); i++) begin
            next_st.alarm[i] = (next_st.cnt[i] > update_timeout);
        end

        // Calculation lookup of one composition float
        if (calc_req.rd) begin
            next_st.cvalid = 1'b1;
            fi = int'(calc_req.index);
            if (calc_req.source == flow_computer_pkg::shared_composition_source) begin
                // Same range whatever stream asks
                if (fi < int'(`MAP_SH_WORDS) / 2) begin
                    stored = {st.sh[2 * fi], st.sh[2 * fi + 1]};
                end
                sub = st.alarm[0];
            end else begin
                // Range of the asking stream
                s = int'(calc_req.stream);
                if (fi < int'(`MAP_PS_TO_OFF) / 2) begin
                    off = s * int'(`MAP_PS_WORDS) + 2 * fi;
                    stored = {st.ps[off], st.ps[off + 1]};
                end
                sub = st.alarm[s + 1];
            end
            // Keypad value replaces downloaded data under alarm
            next_st.cvalue = sub ? calc_req.keypad_value : stored;
            next_st.csub = sub;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------

    // Everything clears to zero except the calendar words
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.dt[0] <= `MAP_DT_RESET0;
            st.dt[1] <= `MAP_DT_RESET0;
            st.dt[2] <= `MAP_DT_RESET0;
            st.dt[3] <= `MAP_DT_RESET3;
            st.dt[4] <= `MAP_DT_RESET4;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign mb_rdata = st.rdata;
    assign mb_ack = st.ack;
    assign mb_err = st.err;
    assign calc_value = st.cvalue;
    assign calc_valid = st.cvalid;
    assign calc_substituted = st.csub;
    assign timeout_alarm = st.alarm;
    assign clock_words = st.dt;

endmodule // flow_computer_modbus_map

`default_nettype wire

// *** hdl/flow_register_map.svh ***
// Register addresses, field positions, reset values and limits of the flow register map
`ifndef FLOW_REGISTER_MAP_SVH
`define FLOW_REGISTER_MAP_SVH

// ----------------------------------------------------------------------------
// Read-only area: virtual streams followed by the flow-rate block
// ----------------------------------------------------------------------------
`define MAP_VS_BASE 32'h0000_01E0
`define MAP_VS_LAST 32'h0000_025E
`define MAP_VS_WORDS 32'h0000_002A
`define MAP_VS_COUNT 32'h0000_0004
`define MAP_VS_FLOATS 32'h0000_0015
`define MAP_FR_BASE 32'h0000_0288
`define MAP_FR_WORDS 32'h0000_0048
`define MAP_RO_WORDS 32'h0000_00F0
`define MAP_TOT_VOL 32'h0000_0003
`define MAP_TOT_MASS 32'h0000_0004
`define MAP_TOT_ENERGY 32'h0000_0005
`define MAP_TOT_PVOL 32'h0000_000C
`define MAP_TOT_PMASS 32'h0000_000D
`define MAP_TOT_PENERGY 32'h0000_000E
`define MAP_ROLLOVER 32'h4B18_9680

// ----------------------------------------------------------------------------
// Read/write area: shared composition, counter, date/time, per-stream blocks
// ----------------------------------------------------------------------------
`define MAP_SH_BASE 32'h0000_0332
`define MAP_SH_WORDS 32'h0000_002C
`define MAP_TO_ADDR 32'h0000_035E
`define MAP_DT_BASE 32'h0000_035F
`define MAP_DT_WORDS 32'h0000_0005
`define MAP_PS_BASE 32'h0000_0366
`define MAP_PS_LAST 32'h0000_04E0
`define MAP_PS_WORDS 32'h0000_0036
`define MAP_PS_COUNT 32'h0000_0008
`define MAP_PS_TO_OFF 32'h0000_0034
`define MAP_PS_ALL 32'h0000_01B0
`define MAP_CNT_COUNT 32'h0000_0009
`define MAP_CNT_MAX 16'hFFFF
`define MAP_WORD_RESET 16'h0000

// ----------------------------------------------------------------------------
// Date/time fields: low byte limits, high byte of word 3 and 4
// ----------------------------------------------------------------------------
`define MAP_DT_LO_POS 0
`define MAP_DT_HI_POS 8
`define MAP_SEC_MAX 8'h3B
`define MAP_HOUR_MAX 8'h17
`define MAP_DAY_MAX 8'h1F
`define MAP_WDAY_MAX 8'h07
`define MAP_YEAR_MAX 8'h63
`define MAP_MONTH_MAX 8'h0C
`define MAP_DT_RESET0 16'h0000
`define MAP_DT_RESET3 16'h0101
`define MAP_DT_RESET4 16'h0001

`endif

// *** hdl/flow_computer_pkg.sv ***
// Types shared by the flow register map
`include "flow_register_map.svh"

package flow_computer_pkg;

    // Which composition range the calculation uses
    typedef enum logic {
        shared_composition_source,
        per_stream_composition_source
    } comp_source_e;

    // One access from the Modbus master
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mb_req_s;

    // One float written by the measurement engine into the read-only area
    typedef struct packed {
        logic we;
        logic [6:0] index;
        logic [31:0] value;
    } meas_upd_s;

    // One composition lookup by the calculation
    typedef struct packed {
        logic rd;
        comp_source_e source;
        logic [2:0] stream;
        logic [4:0] index;
        logic [31:0] keypad_value;
    } calc_req_s;

    // Whole state of the register map
    typedef struct packed {
        logic [`MAP_RO_WORDS-1:0][15:0] ro;
        logic [`MAP_SH_WORDS-1:0][15:0] sh;
        logic [`MAP_PS_ALL-1:0][15:0] ps;
        logic [`MAP_CNT_COUNT-1:0][15:0] cnt;
        logic [`MAP_CNT_COUNT-1:0] alarm;
        logic [`MAP_DT_WORDS-1:0][15:0] dt;
        logic [15:0] rdata;
        logic ack;
        logic err;
        logic [31:0] cvalue;
        logic cvalid;
        logic csub;
    } state_s;

endpackage

// *** bench/flow_map_properties.sv ***
// Concurrent checks on the ports of the flow register map
`timescale 1ns/1ns
`default_nettype none
`include "flow_register_map.svh"
module flow_map_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire flow_computer_pkg::mb_req_s mb_req,
    input wire logic [15:0] mb_rdata,
    input wire logic mb_ack,
    input wire logic mb_err,
    input wire logic timeout_tick,
    input wire logic [15:0] update_timeout,
    input wire flow_computer_pkg::calc_req_s calc_req,
    input wire logic [31:0] calc_value,
    input wire logic calc_valid,
    input wire logic calc_substituted,
    input wire logic [8:0] timeout_alarm,
    input wire logic [79:0] clock_words
);
    // ------------------------------------------------------------
    // Decoded requests
    // ------------------------------------------------------------
    logic req; // Any access taken
    logic wr; // Write only, a read wins
    logic [15:0] a; // Address shorthand
    logic sel; // Alarm bit a lookup depends on
    logic [15:0] d; // Write data shorthand
    assign req = mb_req.rd | mb_req.wr;
    assign wr = mb_req.wr & ~mb_req.rd;
    assign a = mb_req.addr;
    assign d = mb_req.wdata;
    assign sel = calc_req.source ? timeout_alarm[{1'b0, calc_req.stream} + 4'h1] : timeout_alarm[0];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    ack_per_req_a: assert property (req |=> mb_ack)
        else $error("no ack after access");
    no_stray_ack_a: assert property (!req |=> !mb_ack)
        else $error("ack without access");
    ro_write_err_a: assert property (wr && a >= `MAP_VS_BASE && a <= 16'h02CF |=> mb_err)
        else $error("read-only write accepted");
    block_clear_a: assert property (wr && a >= `MAP_SH_BASE && a < `MAP_TO_ADDR |=> !timeout_alarm[0])
        else $error("block write left alarm");
    alarm_level_a: assert property (mb_req.rd && a == `MAP_TO_ADDR && !timeout_tick |=>
        timeout_alarm[0] == (mb_rdata > $past(update_timeout)))
        else $error("alarm disagrees with count");
    sub_choice_a: assert property (calc_req.rd |=> calc_valid && calc_substituted == $past(sel))
        else $error("substitution flag wrong");
    keypad_value_a: assert property (calc_valid && calc_substituted |->
        calc_value == $past(calc_req.keypad_value))
        else $error("keypad value not used");
    date_hold_a: assert property (mb_ack && mb_err |-> $stable(clock_words))
        else $error("refused write changed clock");
    date_write_a: assert property (wr && a == 16'h0362 && d[15:8] inside {[1:31]}
        && d[7:0] inside {[1:7]} |=> clock_words[63:48] == $past(d))
        else $error("date word not stored");
    year_check_a: assert property (wr && a == 16'h0363 && (d[15:8] > 8'h63 || d[7:0] == 8'h00
        || d[7:0] > 8'h0C) |=> mb_err)
        else $error("bad year or month accepted");
    cover property (wr && a == `MAP_VS_BASE ##1 mb_err);
    cover property (calc_valid && calc_substituted);
    cover property (wr && a == `MAP_SH_BASE ##1 !timeout_alarm[0]);
endmodule // flow_map_properties
bind flow_computer_modbus_map flow_map_properties chk (.clk(clk), .rst_n(rst_n),
    .mb_req(mb_req), .mb_rdata(mb_rdata), .mb_ack(mb_ack), .mb_err(mb_err),
    .timeout_tick(timeout_tick), .update_timeout(update_timeout), .calc_req(calc_req),
    .calc_value(calc_value), .calc_valid(calc_valid), .calc_substituted(calc_substituted),
    .timeout_alarm(timeout_alarm), .clock_words(clock_words));
`default_nettype wire

// *** bench/modbus_master_model.sv ***
// Modbus master model issuing register reads and writes
`timescale 1ns/1ns
`default_nettype none
module modbus_master_model (
    input wire logic clk,
    output var flow_computer_pkg::mb_req_s mb_req,
    input wire logic [15:0] mb_rdata,
    input wire logic mb_ack,
    input wire logic mb_err
);
    // Bus idle at time zero
    initial begin
        mb_req = '0;
    end
    // One access after g idle cycles; answer taken one cycle later
    task automatic xfer(input logic w, input logic [15:0] a, d, input int g,
                        output logic [17:0] r);
        repeat (g) @(negedge clk);
        mb_req = {~w, w, a, d};
        @(negedge clk);
        r = {mb_ack, mb_err, mb_rdata};
        // Released lines carry inverted leftovers
        mb_req = {2'b00, ~a, ~d};
    endtask
endmodule // modbus_master_model
`default_nettype wire

// *** bench/test_flow_computer_modbus_map.sv ***
// Self-checking testbench of the flow register map
`timescale 1ns/1ns
`default_nettype none
module test_flow_computer_modbus_map;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk;
    logic rst_n;
    flow_computer_pkg::mb_req_s mb_req;
    logic [15:0] mb_rdata;
    logic mb_ack;
    logic mb_err;
    flow_computer_pkg::meas_upd_s meas_upd;
    logic timeout_tick;
    logic [15:0] update_timeout;
    flow_computer_pkg::calc_req_s calc_req;
    logic [31:0] calc_value;
    logic calc_valid;
    logic calc_substituted;
    logic [8:0] timeout_alarm;
    logic [79:0] clock_words;
    int n_fail = 0; // Mismatches
    int num_checks = 0; // Comparisons
    int cycles = 0; // Watchdog count
    logic [31:0] seed = 32'h0000_005C; // Fixed start, 92
    logic [17:0] r; // Bus answer
    logic [31:0] v; // Scratch value
    logic [31:0] x; // Expected float
    logic [18:0] e; // Date entry
    logic [15:0] cw [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0101, 16'h0001}; // Clock model
    int slots [8] = '{0, 3, 4, 5, 12, 13, 14, 20}; // Float slots tried
    logic [18:0] dts [13] = '{19'h0FF3B, 19'h0003C, 19'h1123B, 19'h20017, 19'h20018, 19'h31F07,
        19'h32001, 19'h30100, 19'h30001, 19'h4630C, 19'h4640C, 19'h4000D, 19'h40000};
    flow_computer_modbus_map dut (.clk(clk), .rst_n(rst_n), .mb_req(mb_req),
        .mb_rdata(mb_rdata), .mb_ack(mb_ack), .mb_err(mb_err), .meas_upd(meas_upd),
        .timeout_tick(timeout_tick), .update_timeout(update_timeout), .calc_req(calc_req),
        .calc_value(calc_value), .calc_valid(calc_valid), .calc_substituted(calc_substituted),
        .timeout_alarm(timeout_alarm), .clock_words(clock_words));
    modbus_master_model master (.clk(clk), .mb_req(mb_req), .mb_rdata(mb_rdata),
        .mb_ack(mb_ack), .mb_err(mb_err));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Stored float: positive totals at or past the limit read as zero
    function automatic logic [31:0] kept(input int s, input logic [31:0] y);
        if (s inside {3, 4, 5, 12, 13, 14} && !y[31] && y >= 32'h4B18_9680) begin
            return 32'h0000_0000;
        end
        return y;
    endfunction
    // Legal contents of each date/time word
    function automatic logic dt_ok(input logic [2:0] w, input logic [15:0] d);
        case (w)
            3'h0, 3'h1: return d[7:0] <= 8'h3B;
            3'h2: return d[7:0] <= 8'h17;
            3'h3: return d[15:8] inside {[1:31]} && d[7:0] inside {[1:7]};
            default: return d[15:8] <= 8'h63 && d[7:0] inside {[1:12]};
        endcase
    endfunction
    // Compare and count
    task automatic chk(input logic [79:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Verdict and stop
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Register write with expected error flag; one edge at least between accesses
    task automatic wr(input logic [15:0] a, d, input logic er);
        master.xfer(1'b1, a, d, 1 + int'(rnd() % 3), r);
        chk(r[17:16], {1'b1, er});
    endtask
    // Register read with expected data; one edge at least between accesses
    task automatic rd(input logic [15:0] a, y);
        master.xfer(1'b0, a, 16'h0000, 1 + int'(rnd() % 3), r);
        chk(r, {2'b10, y});
    endtask
    // Load one measured float
    task automatic meas(input logic [6:0] i, input logic [31:0] y);
        @(negedge clk);
        meas_upd = {1'b1, i, y};
        @(negedge clk);
        meas_upd.we = 1'b0;
    endtask
    // One timeout tick
    task automatic tick();
        @(negedge clk);
        timeout_tick = 1'b1;
        @(negedge clk);
        timeout_tick = 1'b0;
    endtask
    // Composition lookup and its answer
    task automatic calc(input logic s, input logic [2:0] st, input logic [4:0] i,
                        input logic [31:0] y, input logic sub);
        @(negedge clk);
        calc_req = {1'b1, s, st, i, rnd()};
        @(negedge clk);
        chk({calc_valid, calc_substituted, calc_value},
            {1'b1, sub, sub ? calc_req.keypad_value : y});
        calc_req.rd = 1'b0;
    endtask
    // Watchdog
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_fail++;
            end_sim();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        meas_upd = '0;
        timeout_tick = 1'b0;
        update_timeout = 16'h0003;
        calc_req = '0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        chk(clock_words, 80'h0001_0101_0000_0000_0000);
        rd(16'h035E, 16'h0000);
        wr(16'h01E0, 16'(rnd()), 1'b1);
        wr(16'h02CF, 16'(rnd()), 1'b1);
        wr(16'h0364, 16'h0000, 1'b1);
        rd(16'h01E0, 16'h0000);
        $display("test reset and refusals ended");
        for (int k = 0; k < 16; k++) begin
            v = k % 3 == 0 ? 32'h4B18_9680 : (k % 3 == 1 ? 32'h4B18_967F : rnd());
            x = kept(slots[k % 8], v);
            meas(7'((k % 4) * 21 + slots[k % 8]), v);
            rd(16'(480 + (k % 4) * 42 + slots[k % 8] * 2), x[31:16]);
            rd(16'(481 + (k % 4) * 42 + slots[k % 8] * 2), x[15:0]);
        end
        v = rnd();
        meas(7'd84, v);
        rd(16'h0288, v[31:16]);
        rd(16'h0289, v[15:0]);
        $display("test totals ended");
        wr(16'h035E, 16'h0005, 1'b0);
        rd(16'h035E, 16'h0005);
        chk(timeout_alarm, 9'h001);
        calc(1'b0, 3'h2, 5'h00, 32'h0, 1'b1);
        v = rnd();
        wr(16'h0332, v[31:16], 1'b0);
        chk(timeout_alarm, 9'h000);
        wr(16'h0333, v[15:0], 1'b0);
        wr(16'h035C, ~v[31:16], 1'b0);
        wr(16'h035D, ~v[15:0], 1'b0);
        for (int st = 0; st < 8; st++) begin
            calc(1'b0, 3'(st), 5'h00, v, 1'b0);
            calc(1'b0, 3'(st), 5'h15, ~v, 1'b0);
        end
        repeat (3) tick();
        chk(timeout_alarm, 9'h000);
        tick();
        chk(timeout_alarm, 9'h1FF);
        rd(16'h035E, 16'h0004);
        update_timeout = 16'h0004;
        @(negedge clk);
        chk(timeout_alarm, 9'h000);
        update_timeout = 16'h0003;
        calc(1'b1, 3'h7, 5'h00, 32'h0, 1'b1);
        $display("test timeout ended");
        v = rnd();
        wr(16'h04E0, v[31:16], 1'b0);
        wr(16'h04E1, v[15:0], 1'b0);
        chk(timeout_alarm, 9'h0FF);
        calc(1'b1, 3'h7, 5'h00, v, 1'b0);
        wr(16'h0366, v[15:0], 1'b0);
        chk(timeout_alarm, 9'h0FD);
        rd(16'h0366, v[15:0]);
        wr(16'h0514, 16'h0009, 1'b0);
        rd(16'h0514, 16'h0009);
        wr(16'h039B, 16'(rnd()), 1'b0);
        rd(16'h039B, 16'h0000);
        $display("test stream blocks ended");
        for (int k = 0; k < 25; k++) begin
            e = k < 13 ? dts[k] : {3'(rnd() % 5), 16'(rnd()) & 16'h3F1F};
            wr(16'(863 + e[18:16]), e[15:0], !dt_ok(e[18:16], e[15:0]));
            if (dt_ok(e[18:16], e[15:0])) begin
                cw[e[18:16]] = e[15:0];
            end
            chk(clock_words, {cw[4], cw[3], cw[2], cw[1], cw[0]});
            rd(16'(863 + e[18:16]), cw[e[18:16]]);
        end
        $display("test date and time ended");
        end_sim();
    end
endmodule // test_flow_computer_modbus_map
`default_nettype wire
